/* File: logic/sac_adc_control.sv */
// SAR converter control logic with a classic Wishbone register slave.
// Assumes a synchronous bus master on core_clk and an asynchronous comparator pin.
`timescale 1ns/1ps
module sac_adc_control
   import sac_pkg::*;
#(
   parameter int SAMPLE_LEN = SAMPLE_TICKS
) (
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [ADR_W-1:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [3:0] wb_sel_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic haltMode,
   input wire logic compIn,
   output sac_ana_t anaBus
);
   logic ack_reg;
   logic [31:0] rdData_reg;
   logic speed_reg;
   logic convOn_reg;
   logic [CH_W-1:0] channel_reg;
   logic eoc_reg;
   logic [7:0] resultHigh_reg;
   logic [7:0] resultLow_reg;
   logic [1:0] divCnt_reg;
   logic cmpMeta_reg;
   logic cmpSync_reg;
   logic busReq;
   logic csrWrite;
   logic highRead;
   logic run;
   logic tick;
   logic restart;
   logic sampling;
   logic doneStrobe;
   logic [RES_W-1:0] trialCode;
   logic [RES_W-1:0] result;
   logic [7:0] csrView;

   // Bus request seen in the cycle before ack
   assign busReq = wb_cyc_i && wb_stb_i && !ack_reg;
   assign csrWrite = busReq && wb_we_i && wb_sel_i[0] && wb_adr_i == CSR_ADDR;
   assign highRead = busReq && !wb_we_i && wb_adr_i == HIGH_ADDR;

   // Halt stops the converter; wait mode needs no handling
   assign run = convOn_reg && !haltMode;

   // Only a real channel change while running aborts
   assign restart = csrWrite && run && wb_dat_i[CH_MSB:0] != channel_reg;

   assign csrView = {eoc_reg, speed_reg, convOn_reg, 1'b0, channel_reg};

   // Ack one cycle after the request, dropped after one cycle
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         ack_reg <= 1'b0;
      end else begin
         ack_reg <= busReq;
      end
   end

   // Read data; unmapped addresses read zero
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         rdData_reg <= 32'h0000_0000;
      end else if (busReq && !wb_we_i) begin
         unique case (wb_adr_i)
            CSR_ADDR: rdData_reg <= {24'h00_0000, csrView};
            HIGH_ADDR: rdData_reg <= {24'h00_0000, resultHigh_reg};
            LOW_ADDR: rdData_reg <= {24'h00_0000, resultLow_reg};
            default: rdData_reg <= 32'h0000_0000;
         endcase
      end
   end

   assign wb_ack_o = ack_reg;
   assign wb_dat_o = rdData_reg;

   // Writable control fields; reserved bit 4 is not stored
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         speed_reg <= CSR_RESET[SPEED_BIT];
         convOn_reg <= CSR_RESET[ON_BIT];
         channel_reg <= CSR_RESET[CH_MSB:0];
      end else if (csrWrite) begin
         speed_reg <= wb_dat_i[SPEED_BIT];
         convOn_reg <= wb_dat_i[ON_BIT];
         channel_reg <= wb_dat_i[CH_MSB:0];
      end
   end

   // Done flag: completion wins over a clear in the same cycle
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         eoc_reg <= CSR_RESET[EOC_BIT];
      end else if (doneStrobe) begin
         eoc_reg <= 1'b1;
      end else if (highRead || csrWrite) begin
         eoc_reg <= 1'b0;
      end
   end

   // Results are overwritten by every conversion
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         resultHigh_reg <= DATA_RESET;
         resultLow_reg <= DATA_RESET;
      end else if (doneStrobe) begin
         resultHigh_reg <= result[RES_W-1:2];
         resultLow_reg <= {6'h00, result[1:0]};
      end
   end

   // Converter clock enable divided from core_clk
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         divCnt_reg <= 2'h0;
      end else if (!run) begin
         divCnt_reg <= 2'h0;
      end else begin
         divCnt_reg <= divCnt_reg + 2'h1;
      end
   end

   assign tick = run && (speed_reg ? divCnt_reg[0] : divCnt_reg == DIV4_LAST);

   // Comparator pin synchroniser
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         cmpMeta_reg <= 1'b0;
         cmpSync_reg <= 1'b0;
      end else begin
         cmpMeta_reg <= compIn;
         cmpSync_reg <= cmpMeta_reg;
      end
   end

   sac_sar_step #(
      .SAMPLE_LEN(SAMPLE_LEN)
   ) sarStep (
      .core_clk(core_clk),
      .reset_n(reset_n),
      .tick(tick),
      .run(run),
      .restart(restart),
      .cmpBit(cmpSync_reg),
      .sampling(sampling),
      .trialCode(trialCode),
      .doneStrobe(doneStrobe),
      .resultOut(result)
   );

   assign anaBus.enable = run;
   assign anaBus.channel = channel_reg;
   assign anaBus.sample = sampling;
   assign anaBus.trial = trialCode;

   // Checks
   a_done_sets_eoc: assert property (@(posedge core_clk) disable iff (!reset_n)
      doneStrobe |=> eoc_reg)
      else $error("done flag not set after completion");

   a_result_loads: assert property (@(posedge core_clk) disable iff (!reset_n)
      doneStrobe |=> resultHigh_reg == $past(result[RES_W-1:2]) && resultLow_reg[1:0] == $past(result[1:0]))
      else $error("result registers not overwritten");

   a_low_upper_zero: assert property (@(posedge core_clk) disable iff (!reset_n)
      busReq && !wb_we_i && wb_adr_i == LOW_ADDR |=> wb_ack_o && wb_dat_o[31:2] == 30'h0)
      else $error("low result upper bits not zero");

   a_high_read_clears: assert property (@(posedge core_clk) disable iff (!reset_n)
      highRead && !doneStrobe |=> !eoc_reg)
      else $error("high read did not clear done");

   a_csr_write_clears: assert property (@(posedge core_clk) disable iff (!reset_n)
      csrWrite && !doneStrobe |=> !eoc_reg ##1 wb_ack_o == 1'b0)
      else $error("status write did not clear done");

   a_off_no_result: assert property (@(posedge core_clk) disable iff (!reset_n)
      !run ##1 !run |-> !doneStrobe && !anaBus.sample)
      else $error("converter active while off");

   a_halt_disable: assert property (@(posedge core_clk) disable iff (!reset_n)
      haltMode |-> !anaBus.enable && !tick)
      else $error("converter running in halt");

   a_chan_abort: assert property (@(posedge core_clk) disable iff (!reset_n)
      restart && run && !doneStrobe |=> !eoc_reg && (anaBus.sample || !run))
      else $error("channel change did not restart");

   a_div4_gap: assert property (@(posedge core_clk) disable iff (!reset_n)
      (tick && !speed_reg && run) ##1 (!speed_reg && run) [*2] |-> !tick && !$past(tick))
      else $error("divide by four ticks too close");

   a_div2_beat: assert property (@(posedge core_clk) disable iff (!reset_n)
      (tick && speed_reg) ##1 (speed_reg && run) |=> tick)
      else $error("divide by two tick missing");

   a_ack_once: assert property (@(posedge core_clk) disable iff (!reset_n)
      busReq |=> wb_ack_o ##1 !wb_ack_o)
      else $error("ack not a single cycle");
endmodule // sac_adc_control

/* File: logic/sac_pkg.sv */
// Shared constants and types of the SAR converter control block.
// Assumes a 250 MHz core clock and a 32-bit classic Wishbone slave port.
package sac_pkg;
   // Register indices; byte address is four times the index
   localparam logic [7:0] CSR_IDX = 8'h70;
   localparam logic [7:0] HIGH_IDX = 8'h71;
   localparam logic [7:0] LOW_IDX = 8'h72;
   localparam int ADR_W = 12;
   localparam logic [ADR_W-1:0] CSR_ADDR = {2'h0, CSR_IDX, 2'h0};
   localparam logic [ADR_W-1:0] HIGH_ADDR = {2'h0, HIGH_IDX, 2'h0};
   localparam logic [ADR_W-1:0] LOW_ADDR = {2'h0, LOW_IDX, 2'h0};

   // Control/status field positions
   localparam int EOC_BIT = 7;
   localparam int SPEED_BIT = 6;
   localparam int ON_BIT = 5;
   localparam int CH_MSB = 3;
   localparam int CH_W = 4;

   // Reset values
   localparam logic [7:0] CSR_RESET = 8'h00;
   localparam logic [7:0] DATA_RESET = 8'h00;

   // Converter geometry and timing
   localparam int RES_W = 10;
   localparam int SAMPLE_TICKS = 4;
   localparam logic [1:0] DIV4_LAST = 2'h3;

   typedef enum logic [1:0] {
      SAC_IDLE = 2'b00,
      SAC_SAMPLE = 2'b01,
      SAC_SET = 2'b10,
      SAC_DECIDE = 2'b11
   } sac_state_t;

   // Signals toward the analog multiplexer and comparator
   typedef struct packed {
      logic enable;
      logic [CH_W-1:0] channel;
      logic sample;
      logic [RES_W-1:0] trial;
   } sac_ana_t;
endpackage

/* File: logic/sac_sar_step.sv */
// Successive approximation sequencer: sampling, then one set/decide pair per bit.
// Assumes a one-cycle tick enable at the converter rate and a synchronised comparator bit.
`timescale 1ns/1ps
module sac_sar_step
   import sac_pkg::*;
#(
   parameter int SAMPLE_LEN = SAMPLE_TICKS
) (
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic tick,
   input wire logic run,
   input wire logic restart,
   input wire logic cmpBit,
   output logic sampling,
   output logic [RES_W-1:0] trialCode,
   output logic doneStrobe,
   output logic [RES_W-1:0] resultOut
);
   sac_state_t state_reg;
   logic [3:0] bitIdx_reg;
   logic [7:0] sampleCnt_reg;
   logic [RES_W-1:0] trial_reg;

   // Sequencer; restart and stop take effect at once
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         state_reg <= SAC_IDLE;
         bitIdx_reg <= 4'h0;
         sampleCnt_reg <= 8'h00;
         trial_reg <= '0;
      end else if (!run) begin
         state_reg <= SAC_IDLE;
         sampleCnt_reg <= 8'h00;
      end else if (restart || state_reg == SAC_IDLE) begin
         state_reg <= SAC_SAMPLE;
         sampleCnt_reg <= 8'h00;
      end else if (tick) begin
         unique case (state_reg)
            SAC_SAMPLE: begin
               if (sampleCnt_reg == 8'(SAMPLE_LEN - 1)) begin
                  state_reg <= SAC_SET;
                  bitIdx_reg <= 4'(RES_W - 1);
                  trial_reg <= {1'b1, {(RES_W-1){1'b0}}};
               end else begin
                  sampleCnt_reg <= sampleCnt_reg + 8'h01;
               end
            end
            SAC_SET: begin
               state_reg <= SAC_DECIDE;
            end
            SAC_DECIDE: begin
               // Comparator low means the input sits below the trial
               trial_reg[bitIdx_reg] <= cmpBit;
               if (bitIdx_reg == 4'h0) begin
                  state_reg <= SAC_SAMPLE;
                  sampleCnt_reg <= 8'h00;
               end else begin
                  bitIdx_reg <= bitIdx_reg - 4'h1;
                  trial_reg[bitIdx_reg - 4'h1] <= 1'b1;
                  state_reg <= SAC_SET;
               end
            end
            SAC_IDLE: begin
               state_reg <= SAC_SAMPLE;
            end
         endcase
      end
   end

   // Completion pulse with the finished code
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         doneStrobe <= 1'b0;
         resultOut <= '0;
      end else begin
         doneStrobe <= run && !restart && tick && state_reg == SAC_DECIDE && bitIdx_reg == 4'h0;
         resultOut <= {trial_reg[RES_W-1:1], cmpBit};
      end
   end

   assign sampling = state_reg == SAC_SAMPLE;
   assign trialCode = trial_reg;
endmodule // sac_sar_step

/* File: verification/sac_ana_model.sv */
// Behavioural analog front end: one level per channel, compared with the trial code.
// Assumes 11-bit level codes; values above 0x3ff lie over the high reference.
`timescale 1ns/1ps
module sac_ana_model
   import sac_pkg::*;
(
   input wire logic core_clk,
   input wire logic [15:0][10:0] levels,
   input wire sac_ana_t anaBus,
   output logic compIn
);
   logic junk = 1'b0;

   // Meaningless output while converter is off
   always_ff @(posedge core_clk) begin
      junk <= ~junk;
   end

   always_comb begin
      if (anaBus.enable) begin
         compIn = {1'b0, anaBus.trial} <= levels[anaBus.channel];
      end else begin
         compIn = junk;
      end
   end
endmodule // sac_ana_model

/* File: verification/sac_adc_control_bench.sv */
// Self-checking bench for the converter control block.
// Assumes the analog model file and the design package are compiled first.
`timescale 1ns/1ps
module sac_adc_control_bench;
   import sac_pkg::*;
   logic core_clk = 1'b0;
   logic reset_n = 1'b0;
   logic wbCyc = 1'b0;
   logic wbStb = 1'b0;
   logic wbWe = 1'b0;
   logic [ADR_W-1:0] wbAdr = '0;
   logic [31:0] wbDatI = '0;
   logic [3:0] wbSel = 4'h1;
   logic [31:0] wbDatO;
   logic wbAck;
   logic haltMode = 1'b0;
   logic compIn;
   sac_ana_t anaBus;
   logic [15:0][10:0] levels = '0;
   logic [31:0] q;
   logic [7:0] csrVal;
   int errCount = 0;
   int numChecks = 0;
   int cycles = 0;

   initial begin
      forever #2 core_clk = ~core_clk;
   end

   sac_adc_control #(.SAMPLE_LEN(2)) sac_adc_control_inst (.core_clk(core_clk), .reset_n(reset_n),
      .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_dat_i(wbDatI),
      .wb_sel_i(wbSel), .wb_dat_o(wbDatO), .wb_ack_o(wbAck), .haltMode(haltMode), .compIn(compIn),
      .anaBus(anaBus));

   sac_ana_model sac_ana_model_inst (.core_clk(core_clk), .levels(levels), .anaBus(anaBus), .compIn(compIn));

   task automatic conclude;
      $display("checks %0d errors %0d", numChecks, errCount);
      if (errCount == 0 && numChecks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      numChecks++;
      if (seen !== exp) begin
         errCount++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wb(input logic we, input logic [ADR_W-1:0] a, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge core_clk);
      wbCyc <= 1'b1;
      wbStb <= 1'b1;
      wbWe <= we;
      wbAdr <= a;
      wbDatI <= {24'($urandom), d};
      wbSel <= {3'($urandom), 1'b1};
      do begin
         @(posedge core_clk);
         n++;
      end while (wbAck !== 1'b1 && n < 20);
      q = wbDatO;
      wbCyc <= 1'b0;
      wbStb <= 1'b0;
      chk(32'(n < 20), 32'h1);
   endtask

   task automatic rdChk(input logic [ADR_W-1:0] a, input logic [7:0] exp);
      wb(1'b0, a, 8'h00);
      chk(q, {24'h0, exp});
   endtask

   task automatic waitDone;
      int n;
      n = 0;
      do begin
         wb(1'b0, CSR_ADDR, 8'h00);
         n++;
      end while (q[7] !== 1'b1 && n < 300);
      chk(32'(q[7]), 32'h1);
   endtask

   task automatic conv(input int c);
      logic [9:0] e;
      e = (levels[c] > 11'h3ff) ? 10'h3ff : levels[c][9:0];
      waitDone();
      rdChk(LOW_ADDR, {6'h00, e[1:0]});
      rdChk(HIGH_ADDR, e[9:2]);
      rdChk(CSR_ADDR, csrVal);
   endtask

   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 30000) begin
         errCount++;
         conclude();
      end
   end

   initial begin
      void'($urandom(17));
      repeat (20) @(posedge core_clk);
      reset_n <= 1'b1;
      rdChk(CSR_ADDR, 8'h00);
      rdChk(HIGH_ADDR, 8'h00);
      rdChk(LOW_ADDR, 8'h00);
      rdChk(12'h1cc, 8'h00);
      wb(1'b1, CSR_ADDR, 8'hcf);
      rdChk(CSR_ADDR, 8'h4f);
      wb(1'b1, HIGH_ADDR, 8'h55);
      rdChk(HIGH_ADDR, 8'h00);
      for (int c = 0; c < 16; c++) levels[c] = 11'($urandom);
      levels[0] = 11'h000;
      levels[1] = 11'h7ff;
      levels[2] = 11'h400;
      levels[3] = 11'h3ff;
      levels[7] = levels[15] ^ 11'h2aa;
      for (int c = 0; c < 16; c++) begin
         csrVal = {1'b0, 1'(c), 2'b10, 4'(c)};
         wb(1'b1, CSR_ADDR, csrVal);
         conv(c);
      end
      repeat (30) @(posedge core_clk);
      csrVal = 8'h27;
      wb(1'b1, CSR_ADDR, csrVal);
      rdChk(CSR_ADDR, csrVal);
      conv(7);
      waitDone();
      levels[7] = levels[7] ^ 11'h155;
      wb(1'b1, CSR_ADDR, csrVal);
      rdChk(CSR_ADDR, csrVal);
      waitDone();
      wb(1'b1, CSR_ADDR, csrVal);
      conv(7);
      haltMode <= 1'b1;
      wb(1'b1, CSR_ADDR, csrVal);
      repeat (300) @(posedge core_clk);
      rdChk(CSR_ADDR, csrVal);
      haltMode <= 1'b0;
      conv(7);
      waitDone();
      rdChk(HIGH_ADDR, (levels[7] > 11'h3ff) ? 8'hff : levels[7][9:2]);
      rdChk(CSR_ADDR, csrVal);
      csrVal = 8'h07;
      wb(1'b1, CSR_ADDR, csrVal);
      repeat (300) @(posedge core_clk);
      rdChk(CSR_ADDR, csrVal);
      conclude();
   end
endmodule // sac_adc_control_bench
